// >>> mtb_pkg.sv
/* mtb_pkg: constants, encodings and types of the meter pulse back end.
   assumes one 50 MHz clock and energies reported once per line period. */
`default_nettype none
package mtb_pkg;
  // clock and reset sequencing times and low-rate pulse width
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CLK_OFF_US    = 30_000;
  localparam int unsigned DIG_HOLD_US   = 125_000;
  localparam int unsigned LR_PULSE_US   = 31_250;
  localparam int unsigned CLK_OFF_CYC   = CLK_OFF_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned DIG_HOLD_CYC  = DIG_HOLD_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned LR_PULSE_CYC  = LR_PULSE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned SEQ_CW        = 23;
  localparam int unsigned PW_CW         = 21;

  // channel multiplex schedule, in line periods of a 64-period frame
  localparam logic [5:0] SW_NORMAL  = 6'h20;
  localparam logic [5:0] SW_PRIM    = 6'h3c;
  localparam logic [5:0] SW_SEC     = 6'h04;
  localparam logic [5:0] SAMPLE_LEN = 6'h04;
  localparam logic [5:0] WIN_LEN    = 6'h08;
  localparam logic [5:0] EVAL_IDX   = 6'h07;
  localparam logic [5:0] FRAME_LAST = 6'h3f;
  localparam logic [2:0] ENTER_CNT  = 3'h4;

  // criterion: (a+b)/2 * 1/8 and (a+b)/2 * 1/16
  localparam int unsigned THR_SHIFT_HI  = 4;
  localparam int unsigned THR_SHIFT_LO  = 5;

  // phase compensation code
  localparam int unsigned PH_CODE_W = 4;
  localparam int unsigned PH_TAPS   = 16;

  typedef enum logic [1:0] {TS_NORMAL, TS_PRIM, TS_SEC} mtb_tstate_t;

  // active energy events (two per period of P) per low-rate output pulse
  function automatic logic [9:0] mtb_lr_events(input logic [1:0] sel);
    case (sel)
      2'h0:    mtb_lr_events = 10'h080;
      2'h1:    mtb_lr_events = 10'h100;
      2'h2:    mtb_lr_events = 10'h040;
      default: mtb_lr_events = 10'h200;
    endcase
  endfunction
endpackage
`default_nettype wire

// >>> mtb_pulse_if.sv
/* mtb_pulse_if: configuration and pulse lines between the back end and
   its energy pulse generator. assumes one clock domain. */
`timescale 1ns/100ps
`default_nettype none
interface mtb_pulse_if;
  logic       run;
  logic       low_rate;
  logic [1:0] div_sel;
  logic       ae;
  logic       led;
  modport gen (input run, input low_rate, input div_sel, input ae, output led);
  modport ctl (output run, output low_rate, output div_sel, output ae, input led);
endinterface
`default_nettype wire

// >>> mtb_por_seq.sv
/* mtb_por_seq: power-up sequencer that keeps clocks, buffers and logic off.
   assumes rst_n_i comes only from the supply detector. */
`timescale 1ns/100ps
`default_nettype none
module mtb_por_seq #(
  parameter int unsigned OFF_CYC  = mtb_pkg::CLK_OFF_CYC,
  parameter int unsigned HOLD_CYC = mtb_pkg::DIG_HOLD_CYC
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // enables
  output logic      clk_en_o,
  output logic      dc_buf_en_o,
  output logic      dig_run_o
);
  import mtb_pkg::*;

  logic [SEQ_CW-1:0] cnt, next_cnt, age;
  logic              clk_en, next_clk_en, run, next_run;

  always_comb begin
    next_cnt = cnt;
    if (cnt != SEQ_CW'(HOLD_CYC)) begin
      next_cnt = cnt + 1'b1;
    end
    next_clk_en = (next_cnt >= SEQ_CW'(OFF_CYC));
    next_run    = (next_cnt >= SEQ_CW'(HOLD_CYC));
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= '0;
      clk_en <= 1'b0;
      run    <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      clk_en <= next_clk_en;
      run    <= next_run;
    end
  end

  assign clk_en_o    = clk_en;
  assign dc_buf_en_o = clk_en;
  assign dig_run_o   = run;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      age <= '0;
    end else if (age != '1) begin
      age <= age + 1'b1;
    end
  end

  chk_clk_off_time : assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(clk_en_o) |-> age == SEQ_CW'(OFF_CYC) && !dig_run_o)
    else $error("clocks enabled at wrong time");

  chk_dig_hold_time : assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $rose(dig_run_o) |-> age == SEQ_CW'(HOLD_CYC) && clk_en_o && dc_buf_en_o)
    else $error("digital reset released at wrong time");
endmodule
`default_nettype wire

// >>> mtb_pulse_gen.sv
/* mtb_pulse_gen: energy to frequency output for the led pin.
   assumes ae is a one-cycle pulse at twice the full output rate P. */
`timescale 1ns/100ps
`default_nettype none
module mtb_pulse_gen #(
  parameter int unsigned PW_CYC = mtb_pkg::LR_PULSE_CYC
) (
  // clock and reset
  input  wire logic  mclk_i,
  input  wire logic  rst_n_i,
  // control and pulse
  mtb_pulse_if.gen   p
);
  import mtb_pkg::*;

  logic             tog, next_tog, led, next_led;
  logic [9:0]       ev, next_ev;
  logic [PW_CW-1:0] wcnt, next_wcnt, hi_len;

  always_comb begin
    next_tog  = tog;
    next_ev   = ev;
    next_wcnt = wcnt;
    if (!p.run) begin
      next_tog  = 1'b0;
      next_ev   = '0;
      next_wcnt = '0;
    end else begin
      if (p.ae) begin
        next_tog = ~tog;
      end
      if (wcnt != '0) begin
        next_wcnt = wcnt - 1'b1;
      end
      if (p.low_rate && p.ae) begin
        if (ev >= mtb_lr_events(p.div_sel) - 10'h001) begin
          next_ev   = '0;
          next_wcnt = PW_CW'(PW_CYC);
        end else begin
          next_ev = ev + 1'b1;
        end
      end
    end
    next_led = p.low_rate ? (next_wcnt != '0) : next_tog;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog  <= 1'b0;
      ev   <= '0;
      wcnt <= '0;
      led  <= 1'b0;
    end else begin
      tog  <= next_tog;
      ev   <= next_ev;
      wcnt <= next_wcnt;
      led  <= next_led;
    end
  end

  assign p.led = led;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hi_len <= '0;
    end else begin
      hi_len <= led ? hi_len + 1'b1 : '0;
    end
  end

  chk_lr_width : assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    $fell(led) && $past(p.low_rate) && $past(p.run) |-> hi_len == PW_CW'(PW_CYC))
    else $error("low rate pulse width wrong");

  chk_full_rate : assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    p.run && !p.low_rate && p.ae |=> led != $past(led))
    else $error("full rate output did not toggle");
endmodule
`default_nettype wire

// >>> mtb_backend.sv
/* mtb_backend: meter back end with tamper channel multiplexer, phase
   compensation, power-up sequencing and energy pulse output.
   assumes energies of both current channels arrive with line_tick_i. */
`timescale 1ns/100ps
`default_nettype none
module mtb_backend #(
  parameter int unsigned EW       = 24,
  parameter int unsigned OFF_CYC  = mtb_pkg::CLK_OFF_CYC,
  parameter int unsigned HOLD_CYC = mtb_pkg::DIG_HOLD_CYC,
  parameter int unsigned PW_CYC   = mtb_pkg::LR_PULSE_CYC
) (
  // clock and power-on reset
  input  wire logic                              mclk_i,
  input  wire logic                              rst_n_i,
  // configuration shadow latches
  input  wire logic                              cfg_load_i,
  input  wire logic [mtb_pkg::PH_CODE_W-1:0]     phase_comp_code_i,
  input  wire logic                              low_rate_select_i,
  input  wire logic [1:0]                        pulse_divider_select_i,
  input  wire logic                              tamper_threshold_select_i,
  // sigma-delta streams
  input  wire logic                              sd_stb_i,
  input  wire logic                              sd_volt_i,
  input  wire logic                              sd_prim_i,
  input  wire logic                              sd_sec_i,
  input  wire logic [2:0]                        sd_stuck_i,
  // line period energies and qualifiers
  input  wire logic                              line_tick_i,
  input  wire logic [EW-1:0]                     prim_energy_i,
  input  wire logic [EW-1:0]                     sec_energy_i,
  input  wire logic                              period_bad_i,
  input  wire logic                              no_load_i,
  input  wire logic                              active_energy_pulse_i,
  // power-up sequencing
  output logic                                   clk_en_o,
  output logic                                   dc_buf_en_o,
  output logic                                   dig_run_o,
  // datapath
  output logic                                   sd_volt_o,
  output logic                                   sd_curr_o,
  output logic                                   chan_sec_o,
  output logic [EW-1:0]                          calc_energy_o,
  // tamper and pulse pins
  output mtb_pkg::mtb_tstate_t                   tamper_state_o,
  output logic                                   shared_tamper_output_pin_n_o,
  output logic                                   led_o
);
  import mtb_pkg::*;

  localparam int unsigned ACW = EW + 3;

  ////////////////////////////////////////////////////////////////////////////
  // power-up sequencing
  mtb_por_seq #(
    .OFF_CYC  (OFF_CYC),
    .HOLD_CYC (HOLD_CYC)
  ) u_por (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .clk_en_o    (clk_en_o),
    .dc_buf_en_o (dc_buf_en_o),
    .dig_run_o   (dig_run_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration shadow latches
  logic [PH_CODE_W-1:0] phc, next_phc;
  logic                 lrs, next_lrs, thr, next_thr;
  logic [1:0]           pds, next_pds;

  always_comb begin
    next_phc = phc;
    next_lrs = lrs;
    next_pds = pds;
    next_thr = thr;
    if (!dig_run_o) begin
      next_phc = '0;
      next_lrs = 1'b0;
      next_pds = '0;
      next_thr = 1'b0;
    end else if (cfg_load_i) begin
      next_phc = phase_comp_code_i;
      next_lrs = low_rate_select_i;
      next_pds = pulse_divider_select_i;
      next_thr = tamper_threshold_select_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phc <= '0;
      lrs <= 1'b0;
      pds <= '0;
      thr <= 1'b0;
    end else begin
      phc <= next_phc;
      lrs <= next_lrs;
      pds <= next_pds;
      thr <= next_thr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel multiplexer and phase compensation
  logic [PH_TAPS-1:0] cdl, next_cdl;
  logic               vq, next_vq, cq, next_cq, csel, next_csel, cur_bit;

  assign cur_bit = csel ? sd_sec_i : sd_prim_i;

  always_comb begin
    next_cdl = cdl;
    next_vq  = vq;
    next_cq  = cq;
    if (!dig_run_o) begin
      next_cdl = '0;
      next_vq  = 1'b0;
      next_cq  = 1'b0;
    end else if (sd_stb_i) begin
      next_cdl = {cdl[PH_TAPS-2:0], cur_bit};
      next_vq  = sd_volt_i;
      next_cq  = next_cdl[phc];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cdl <= '0;
      vq  <= 1'b0;
      cq  <= 1'b0;
    end else begin
      cdl <= next_cdl;
      vq  <= next_vq;
      cq  <= next_cq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tamper state, sampling window and criterion
  mtb_tstate_t    tst, next_tst, cand, next_cand, res;
  logic [2:0]     tcnt, next_tcnt;
  logic [5:0]     pcnt, next_pcnt, sw, dwin;
  logic [ACW-1:0] acc_a, next_acc_a, acc_b, next_acc_b, b_fin, diff, thr_v;
  logic [EW-1:0]  calc, next_calc, held, next_held;
  logic           pin_n, next_pin_n, dis, gap;

  assign dis = period_bad_i | no_load_i | (|sd_stuck_i);
  assign gap = (tst != TS_NORMAL) && (csel != (tst == TS_SEC));

  always_comb begin
    case (tst)
      TS_PRIM: sw = SW_PRIM;
      TS_SEC:  sw = SW_SEC;
      default: sw = SW_NORMAL;
    endcase
    dwin  = pcnt - sw + SAMPLE_LEN;
    b_fin = acc_b + ACW'(sec_energy_i);
    diff  = (acc_a > b_fin) ? acc_a - b_fin : b_fin - acc_a;
    thr_v = (acc_a + b_fin) >> (thr ? THR_SHIFT_LO : THR_SHIFT_HI);
    if (diff <= thr_v) begin
      res = TS_NORMAL;
    end else if (acc_a > b_fin) begin
      res = TS_PRIM;
    end else begin
      res = TS_SEC;
    end
  end

  always_comb begin
    next_tst   = tst;
    next_cand  = cand;
    next_tcnt  = tcnt;
    next_pcnt  = pcnt;
    next_acc_a = acc_a;
    next_acc_b = acc_b;
    next_calc  = calc;
    next_held  = held;
    if (!dig_run_o || dis) begin
      next_tst   = TS_NORMAL;
      next_cand  = TS_NORMAL;
      next_tcnt  = '0;
      next_pcnt  = '0;
      next_acc_a = '0;
      next_acc_b = '0;
      if (!dig_run_o) begin
        next_calc = '0;
        next_held = '0;
      end
    end else if (line_tick_i) begin
      next_pcnt = pcnt + 6'h01;
      if (gap) begin
        next_calc = held;
      end else begin
        next_calc = csel ? sec_energy_i : prim_energy_i;
        next_held = csel ? sec_energy_i : prim_energy_i;
      end
      if (dwin < SAMPLE_LEN) begin
        next_acc_a = acc_a + ACW'(prim_energy_i);
      end else if (dwin < WIN_LEN) begin
        next_acc_b = b_fin;
      end
      if (dwin == EVAL_IDX) begin
        next_acc_a = '0;
        next_acc_b = '0;
        if (res == tst) begin
          next_tcnt = '0;
        end else if (res == cand && tcnt != '0) begin
          next_tcnt = tcnt + 3'h1;
        end else begin
          next_cand = res;
          next_tcnt = 3'h1;
        end
        if (next_tcnt == ENTER_CNT) begin
          next_tst  = next_cand;
          next_tcnt = '0;
        end
      end
    end
    case (next_tst)
      TS_PRIM: next_csel = (next_pcnt >= SW_PRIM);
      TS_SEC:  next_csel = (next_pcnt >= SW_SEC);
      default: next_csel = (next_pcnt >= SW_NORMAL);
    endcase
    next_pin_n = (next_tst == TS_NORMAL);
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tst   <= TS_NORMAL;
      cand  <= TS_NORMAL;
      tcnt  <= '0;
      pcnt  <= '0;
      acc_a <= '0;
      acc_b <= '0;
      calc  <= '0;
      held  <= '0;
      csel  <= 1'b0;
      pin_n <= 1'b1;
    end else begin
      tst   <= next_tst;
      cand  <= next_cand;
      tcnt  <= next_tcnt;
      pcnt  <= next_pcnt;
      acc_a <= next_acc_a;
      acc_b <= next_acc_b;
      calc  <= next_calc;
      held  <= next_held;
      csel  <= next_csel;
      pin_n <= next_pin_n;
    end
  end

  assign sd_volt_o                    = vq;
  assign sd_curr_o                    = cq;
  assign chan_sec_o                   = csel;
  assign calc_energy_o                = calc;
  assign tamper_state_o               = tst;
  assign shared_tamper_output_pin_n_o = pin_n;

  ////////////////////////////////////////////////////////////////////////////
  // energy pulse output
  mtb_pulse_if pif ();

  assign pif.run      = dig_run_o;
  assign pif.low_rate = lrs;
  assign pif.div_sel  = pds;
  assign pif.ae       = active_energy_pulse_i;
  assign led_o        = pif.led;

  mtb_pulse_gen #(
    .PW_CYC (PW_CYC)
  ) u_pulse (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .p       (pif.gen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_dis_normal : assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    dig_run_o && dis |=> tamper_state_o == TS_NORMAL && !chan_sec_o)
    else $error("tamper not forced to normal");

  chk_pin_level : assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    shared_tamper_output_pin_n_o == (tamper_state_o == TS_NORMAL))
    else $error("tamper pin disagrees with state");

  chk_prim_ratio : assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    dig_run_o && !dis && line_tick_i && tst == TS_PRIM && pcnt == SW_PRIM - 6'h01
    |=> chan_sec_o ##0 tamper_state_o == TS_PRIM)
    else $error("primary tamper ratio wrong");

  chk_sec_ratio : assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    dig_run_o && !dis && line_tick_i && tst == TS_SEC && pcnt == FRAME_LAST
    |=> !chan_sec_o)
    else $error("secondary tamper ratio wrong");

  chk_gap_hold : assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    dig_run_o && !dis && line_tick_i && tst == TS_PRIM && csel && pcnt != FRAME_LAST
    |=> $stable(calc_energy_o))
    else $error("gap energy not held");

  chk_four_results : assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    dig_run_o && !dis && next_tst != tst |-> line_tick_i && tcnt == ENTER_CNT - 3'h1)
    else $error("state changed without four results");

  chk_phase_zero : assert property (
    @(posedge mclk_i) disable iff (!rst_n_i)
    dig_run_o && sd_stb_i && phc == '0 |=> sd_curr_o == $past(cur_bit)
    && sd_volt_o == $past(sd_volt_i))
    else $error("phase path adds delay");
endmodule
`default_nettype wire

// >>> mtb_meter_probe.sv
/* mtb_meter_probe: pulse reader standing in for the calibration bench.
   assumes led_i is a registered level on mclk_i. */
`timescale 1ns/100ps
`default_nettype none
module mtb_meter_probe (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // pulse pin
  input  wire logic        led_i,
  // measurements
  output logic      [15:0] rise_cnt_o,
  output logic      [23:0] high_len_o,
  output logic      [23:0] low_len_o
);
  logic        prev;
  logic [23:0] run;

  // count rising edges and the length of each high and low run
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev       <= 1'b0;
      run        <= 24'h0;
      rise_cnt_o <= 16'h0;
      high_len_o <= 24'h0;
      low_len_o  <= 24'h0;
    end else begin
      prev <= led_i;
      if (led_i != prev) begin
        run <= 24'h1;
        if (prev) high_len_o <= run;
        else begin
          low_len_o  <= run;
          rise_cnt_o <= rise_cnt_o + 16'h1;
        end
      end else run <= run + 24'h1;
    end
  end
endmodule
`default_nettype wire

// >>> mtb_backend_tb_top.sv
/* mtb_backend_tb_top: self-checking bench of the meter back end.
   assumes shortened sequencing and pulse-width parameters. */
`timescale 1ns/100ps
`default_nettype none
module mtb_backend_tb_top;
  import mtb_pkg::*;
  localparam int unsigned OFF  = 20;
  localparam int unsigned HOLD = 50;
  localparam int unsigned PW   = 10;
  localparam logic [63:0] PAT  = 64'h9e37_4c1b_d2a5_0f68;

  logic        mclk_i, rst_n_i, cfg_load_i, low_rate_select_i, tamper_threshold_select_i;
  logic [3:0]  phase_comp_code_i;
  logic [1:0]  pulse_divider_select_i;
  logic        sd_stb_i, sd_volt_i, sd_prim_i, sd_sec_i, line_tick_i;
  logic        period_bad_i, no_load_i, active_energy_pulse_i;
  logic [2:0]  sd_stuck_i;
  logic [23:0] prim_energy_i, sec_energy_i, calc_energy_o, high_len, low_len;
  logic        clk_en_o, dc_buf_en_o, dig_run_o, sd_volt_o, sd_curr_o, chan_sec_o;
  logic        shared_tamper_output_pin_n_o, led_o;
  logic [15:0] rise_cnt, r0;
  mtb_tstate_t tamper_state_o;
  int          n_errors, checks, n, code, nt;

  mtb_backend #(.EW(24), .OFF_CYC(OFF), .HOLD_CYC(HOLD), .PW_CYC(PW)) u_dut (
    .mclk_i, .rst_n_i, .cfg_load_i, .phase_comp_code_i, .low_rate_select_i,
    .pulse_divider_select_i, .tamper_threshold_select_i, .sd_stb_i, .sd_volt_i,
    .sd_prim_i, .sd_sec_i, .sd_stuck_i, .line_tick_i, .prim_energy_i, .sec_energy_i,
    .period_bad_i, .no_load_i, .active_energy_pulse_i, .clk_en_o, .dc_buf_en_o,
    .dig_run_o, .sd_volt_o, .sd_curr_o, .chan_sec_o, .calc_energy_o, .tamper_state_o,
    .shared_tamper_output_pin_n_o, .led_o);

  mtb_meter_probe u_probe (.mclk_i, .rst_n_i, .led_i(led_o), .rise_cnt_o(rise_cnt),
    .high_len_o(high_len), .low_len_o(low_len));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic cfg(input logic [3:0] ph, input logic lr, input logic [1:0] dv,
                     input logic th);
    @(posedge mclk_i);
    cfg_load_i                <= 1'b1;
    phase_comp_code_i         <= ph;
    low_rate_select_i         <= lr;
    pulse_divider_select_i    <= dv;
    tamper_threshold_select_i <= th;
    @(posedge mclk_i);
    cfg_load_i <= 1'b0;
  endtask

  task automatic ae_pulses(input int cnt, input int gap);
    repeat (cnt) begin
      @(posedge mclk_i);
      active_energy_pulse_i <= 1'b1;
      @(posedge mclk_i);
      active_energy_pulse_i <= 1'b0;
      repeat (gap - 2) @(posedge mclk_i);
    end
  endtask

  task automatic ticks(input int cnt, input logic [23:0] a, input logic [23:0] b);
    repeat (cnt) begin
      @(posedge mclk_i);
      line_tick_i   <= 1'b1;
      prim_energy_i <= a;
      sec_energy_i  <= b;
      @(posedge mclk_i);
      line_tick_i <= 1'b0;
    end
    @(negedge mclk_i);
  endtask

  task automatic state_is(input mtb_tstate_t s);
    check("tamper state", tamper_state_o, s);
    check("tamper pin", shared_tamper_output_pin_n_o, s == TS_NORMAL);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n_i, cfg_load_i, low_rate_select_i, tamper_threshold_select_i} = 4'h0;
    {phase_comp_code_i, pulse_divider_select_i, sd_stuck_i} = 9'h0;
    {sd_stb_i, sd_volt_i, sd_prim_i, sd_sec_i, line_tick_i} = 5'h0;
    {period_bad_i, no_load_i, active_energy_pulse_i} = 3'h0;
    prim_energy_i = 24'h0;
    sec_energy_i  = 24'h0;
    n_errors = 0;
    checks   = 0;
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    check("enables in reset", {clk_en_o, dc_buf_en_o, dig_run_o, led_o}, 4'h0);
    state_is(TS_NORMAL);
    @(posedge mclk_i);
    rst_n_i <= 1'b1;
    n = 0;
    while (clk_en_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    check("clock enable edge", n, OFF + 1);
    check("buffer enable", dc_buf_en_o, 1'b1);
    check("early digital run", dig_run_o, 1'b0);
    while (dig_run_o !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    check("digital run edge", n, HOLD + 1);
    if (n >= 100) give_verdict();
    $display("power-up test done");

    for (int p = 0; p < 3; p++) begin
      code = (p == 0) ? 0 : (p == 1) ? 5 : 15;
      if (p > 0) cfg(code[3:0], 1'b0, 2'h0, 1'b0);
      for (int i = 0; i < 40; i++) begin
        @(posedge mclk_i);
        sd_stb_i  <= 1'b1;
        sd_prim_i <= PAT[i];
        sd_sec_i  <= ~PAT[i];
        sd_volt_i <= PAT[i+7];
        @(negedge mclk_i);
        if (i > code) check("current stream", sd_curr_o, PAT[i-1-code]);
        if (i > 0) check("voltage stream", sd_volt_o, PAT[i+6]);
      end
    end
    @(posedge mclk_i);
    sd_stb_i <= 1'b0;
    $display("phase test done");

    for (int s = 0; s < 4; s++) begin
      cfg(4'h0, 1'b1, s[1:0], 1'b0);
      nt = (s == 0) ? 128 : (s == 1) ? 256 : (s == 2) ? 64 : 512;
      r0 = rise_cnt;
      ae_pulses(nt - 1, 2);
      repeat (4) @(negedge mclk_i);
      check("low-rate early pulse", rise_cnt, r0);
      ae_pulses(1, 2);
      repeat (PW + 4) @(negedge mclk_i);
      check("low-rate pulse count", rise_cnt, r0 + 16'h1);
      check("low-rate pulse width", high_len, PW);
    end
    cfg(4'h0, 1'b0, 2'h0, 1'b0);
    ae_pulses(6, 4);
    repeat (4) @(negedge mclk_i);
    check("full-rate high", high_len, 24'h4);
    check("full-rate low", low_len, 24'h4);
    check("full-rate level", led_o, 1'b0);
    $display("pulse test done");

    ticks(256, 24'h3e8, 24'h384);
    state_is(TS_NORMAL);
    cfg(4'h0, 1'b0, 2'h0, 1'b1);
    ticks(192, 24'h3e8, 24'h384);
    state_is(TS_NORMAL);
    ticks(64, 24'h3e8, 24'h384);
    state_is(TS_PRIM);
    ticks(31, 24'h3e8, 24'h384);
    check("primary selected", {chan_sec_o, calc_energy_o}, {1'b0, 24'h3e8});
    ticks(29, 24'h3e8, 24'h384);
    ticks(2, 24'h4b0, 24'h384);
    check("gap energy", {chan_sec_o, calc_energy_o}, {1'b1, 24'h3e8});
    ticks(2, 24'h3e8, 24'h384);
    ticks(192, 24'h3e8, 24'h3e8);
    state_is(TS_PRIM);
    ticks(64, 24'h3e8, 24'h3e8);
    state_is(TS_NORMAL);
    for (int c = 0; c < 3; c++) begin
      ticks(256, 24'h384, 24'h3e8);
      state_is(TS_SEC);
      @(posedge mclk_i);
      period_bad_i <= (c == 0);
      no_load_i    <= (c == 1);
      sd_stuck_i   <= (c == 2) ? 3'h4 : 3'h0;
      @(posedge mclk_i);
      {period_bad_i, no_load_i, sd_stuck_i} <= 5'h0;
      @(negedge mclk_i);
      state_is(TS_NORMAL);
    end
    ticks(10, 24'h3e8, 24'h3e8);
    @(posedge mclk_i);
    no_load_i <= 1'b1;
    @(posedge mclk_i);
    no_load_i <= 1'b0;
    ticks(22, 24'h3e8, 24'h3e8);
    check("frame restart", chan_sec_o, 1'b0);
    ticks(10, 24'h3e8, 24'h3e8);
    check("frame switch", chan_sec_o, 1'b1);
    $display("tamper test done");
    give_verdict();
  end
endmodule
`default_nettype wire
